// file: include/tmsb_pkg.sv
package tmsb_pkg;
  localparam logic [4:0] ADDR_HI_BITS = 5'h0b;
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int NUM_REGS = 16;
  localparam logic [7:0] OFFSET_REG_BASE = 8'h04;
  localparam logic [7:0] OVERTEMP_OUTPUT_LIMIT_BASE = 8'h06;
  localparam logic [7:0] FAN_START_REG = 8'h08;
  localparam logic [7:0] FAN_SPAN_REG = 8'h09;
  localparam logic [7:0] TEMP_LOC_REG = 8'h0a;
  localparam logic [7:0] TEMP_REM_REG = 8'h0b;
  localparam logic [7:0] FAN_DUTY_REG = 8'h0c;
  localparam logic [7:0] ALERT_MASK_REG = 8'h0d;
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_VCC = 2'h1;
  localparam logic [1:0] STRAP_OPEN = 2'h2;
  localparam logic [1:0] LOW_BITS_GND = 2'h0;
  localparam logic [1:0] LOW_BITS_VCC = 2'h1;
  localparam logic [1:0] LOW_BITS_OPEN = 2'h2;
  localparam logic [3:0] BIT_COUNT_BYTE = 4'h8;
  localparam logic [15:0] MON_PERIOD = 16'h03e8;

  typedef struct packed {
    logic [7:0] loc;
    logic [7:0] rem;
  } tmsb_temps_t;

  typedef struct packed {
    logic overtemp;
    logic fan_on;
    logic [7:0] fan_duty;
    logic alert_n;
  } tmsb_status_t;
endpackage : tmsb_pkg

// file: logic/tmsb_pin_sync.sv
`timescale 1ns/1ps
module tmsb_pin_sync (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [3:0] d,
  output logic [3:0] q
);
  logic [3:0] meta_r;
  // Bus pins idle high in reset; strap bits keep flowing so capture sees the pad
  always_ff @(posedge CLK) begin
    if (RST) begin
      meta_r <= {2'h3, d[1:0]};
      q <= {2'h3, meta_r[1:0]};
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : tmsb_pin_sync

// file: logic/tmsb_smbus_slave.sv
`timescale 1ns/1ps
module tmsb_smbus_slave
  import tmsb_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic [1:0] STRAP_STATE,
  input wire tmsb_pkg::tmsb_temps_t TEMPS_IN,
  output tmsb_pkg::tmsb_status_t STATUS,
  output logic [7:0] ADDR_POINTER
);
  import tmsb_pkg::*;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_AACK = 7'b0000100,
    ST_WBYTE = 7'b0001000,
    ST_WACK = 7'b0010000,
    ST_RBYTE = 7'b0100000,
    ST_RACK = 7'b1000000
  } tmsb_state_t;

  tmsb_state_t state_r;
  logic [3:0] sync_q;
  logic scl_r, sda_r, scl_d_r, sda_d_r;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic [1:0] strap_low_r;
  logic strap_done_r;
  logic [6:0] own_addr;
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic rw_r, ara_r;
  logic [1:0] wcount_r;
  logic [7:0] tx_r;
  logic [7:0] regs_r [NUM_REGS];
  logic [7:0] ptr_r;
  logic alert_r, served_r, fault_r;
  logic [15:0] mon_cnt_r;
  logic mon_tick;
  logic sda_oe_r, arb_lost_r;
  tmsb_status_t status_r;

  function automatic logic [7:0] add_offset(input logic [7:0] t, input logic [4:0] off);
    logic [8:0] s;
    s = {t[7], t} + {{4{off[4]}}, off};
    add_offset = s[7:0];
  endfunction : add_offset

  function automatic logic ge_signed(input logic [7:0] a, input logic [7:0] b);
    ge_signed = $signed(a) >= $signed(b);
  endfunction : ge_signed

  function automatic logic [7:0] reg_read(input logic [7:0] p);
    reg_read = (p < 8'(NUM_REGS)) ? regs_r[p[3:0]] : 8'h00;
  endfunction : reg_read

  tmsb_pin_sync u_sync (
    .CLK(CLK),
    .RST(RST),
    .d({SCL_IN, SDA_IN, STRAP_STATE}),
    .q(sync_q)
  );

  always_ff @(posedge CLK) begin
    if (RST) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_r <= sync_q[3];
      sda_r <= sync_q[2];
      scl_d_r <= scl_r;
      sda_d_r <= sda_r;
    end
  end

  assign scl_rise = scl_r & ~scl_d_r;
  assign scl_fall = ~scl_r & scl_d_r;
  assign start_ev = scl_r & scl_d_r & sda_d_r & ~sda_r;
  assign stop_ev = scl_r & scl_d_r & ~sda_d_r & sda_r;

  // Strap caught once after each reset release; held until the next reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      strap_done_r <= 1'b0;
      strap_low_r <= LOW_BITS_OPEN;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      if (sync_q[1:0] == STRAP_GND) begin
        strap_low_r <= LOW_BITS_GND;
      end else if (sync_q[1:0] == STRAP_VCC) begin
        strap_low_r <= LOW_BITS_VCC;
      end else begin
        strap_low_r <= LOW_BITS_OPEN;
      end
    end
  end

  assign own_addr = {ADDR_HI_BITS, strap_low_r};

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_r <= ST_IDLE;
      shift_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      rw_r <= 1'b0;
      ara_r <= 1'b0;
      wcount_r <= 2'h0;
    end else if (start_ev) begin
      state_r <= ST_ADDR;
      bit_cnt_r <= 4'h0;
      wcount_r <= 2'h0;
    end else if (stop_ev) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_ADDR: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == BIT_COUNT_BYTE) begin
            bit_cnt_r <= 4'h0;
            rw_r <= shift_r[0];
            ara_r <= (shift_r[7:1] == ARA_ADDR) && shift_r[0] && alert_r;
            if (shift_r[7:1] == own_addr
                || ((shift_r[7:1] == ARA_ADDR) && shift_r[0] && alert_r)) begin
              state_r <= ST_AACK;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            state_r <= rw_r ? ST_RBYTE : ST_WBYTE;
          end
        end
        ST_WBYTE: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == BIT_COUNT_BYTE) begin
            bit_cnt_r <= 4'h0;
            // Third and later bytes are not acknowledged
            if (wcount_r < 2'h2) begin
              state_r <= ST_WACK;
              wcount_r <= wcount_r + 2'h1;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            state_r <= ST_WBYTE;
          end
        end
        ST_RBYTE: begin
          if (scl_fall) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == BIT_COUNT_BYTE - 4'h1) begin
              state_r <= ST_RACK;
              bit_cnt_r <= 4'h0;
            end
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Pointer and register writes on the ack-entry edge of the first two written bytes
  always_ff @(posedge CLK) begin
    if (RST) begin
      ptr_r <= PTR_RESET;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= REG_RESET;
      end
    end else begin
      if (state_r == ST_WBYTE && scl_fall && bit_cnt_r == BIT_COUNT_BYTE && !stop_ev
          && !start_ev) begin
        if (wcount_r == 2'h0) begin
          ptr_r <= shift_r;
        end else if (wcount_r == 2'h1 && ptr_r < 8'(NUM_REGS)
                     && ptr_r != TEMP_LOC_REG && ptr_r != TEMP_REM_REG) begin
          regs_r[ptr_r[3:0]] <= shift_r;
        end
      end
      if (mon_tick) begin
        regs_r[TEMP_LOC_REG[3:0]] <= add_offset(TEMPS_IN.loc, regs_r[OFFSET_REG_BASE[3:0]][4:0]);
        regs_r[TEMP_REM_REG[3:0]] <= add_offset(TEMPS_IN.rem,
                                                regs_r[OFFSET_REG_BASE[3:0] + 4'h1][4:0]);
      end
    end
  end

  // Read data loaded at ack end, shifted on each low phase
  always_ff @(posedge CLK) begin
    if (RST) begin
      tx_r <= 8'h00;
    end else if (state_r == ST_AACK && scl_fall && rw_r) begin
      tx_r <= ara_r ? {own_addr, 1'b0} : reg_read(ptr_r);
    end else if (state_r == ST_RBYTE && scl_fall) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // Open-drain: drive low only for ack and for zero data bits
  always_ff @(posedge CLK) begin
    if (RST) begin
      sda_oe_r <= 1'b0;
    end else if (start_ev || stop_ev) begin
      sda_oe_r <= 1'b0;
    end else if (scl_fall) begin
      if (state_r == ST_ADDR && bit_cnt_r == BIT_COUNT_BYTE) begin
        sda_oe_r <= (shift_r[7:1] == own_addr)
                    || ((shift_r[7:1] == ARA_ADDR) && shift_r[0] && alert_r);
      end else if (state_r == ST_WBYTE && bit_cnt_r == BIT_COUNT_BYTE) begin
        sda_oe_r <= (wcount_r < 2'h2);
      end else if (state_r == ST_AACK && rw_r) begin
        sda_oe_r <= ara_r ? ~own_addr[6] : (reg_read(ptr_r) < 8'h80);
      end else if (state_r == ST_RBYTE && bit_cnt_r != BIT_COUNT_BYTE - 4'h1) begin
        sda_oe_r <= ~tx_r[6] && !arb_lost_r;
      end else begin
        sda_oe_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || start_ev) begin
      arb_lost_r <= 1'b0;
    end else if (state_r == ST_RBYTE && ara_r && scl_rise && !sda_oe_r && !sda_r) begin
      arb_lost_r <= 1'b1;
    end
  end
  // Drive pin only low, the enable carries each bit; losing address bit yields to lower address
  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_oe_r;

  // Monitor tick divides the clock down to the comparison rate
  always_ff @(posedge CLK) begin
    if (RST) begin
      mon_cnt_r <= 16'h0000;
    end else if (mon_cnt_r == MON_PERIOD - 16'h0001) begin
      mon_cnt_r <= 16'h0000;
    end else begin
      mon_cnt_r <= mon_cnt_r + 16'h0001;
    end
  end
  assign mon_tick = (mon_cnt_r == MON_PERIOD - 16'h0001);

  always_ff @(posedge CLK) begin
    if (RST) begin
      fault_r <= 1'b0;
    end else if (mon_tick) begin
      fault_r <= ge_signed(regs_r[TEMP_LOC_REG[3:0]], regs_r[OVERTEMP_OUTPUT_LIMIT_BASE[3:0]])
                 || ge_signed(regs_r[TEMP_REM_REG[3:0]],
                              regs_r[OVERTEMP_OUTPUT_LIMIT_BASE[3:0] + 4'h1]);
    end
  end

  // Alert cleared by a finished response; set wins on a new monitor tick
  always_ff @(posedge CLK) begin
    if (RST) begin
      alert_r <= 1'b0;
      served_r <= 1'b0;
    end else begin
      served_r <= ara_r && state_r == ST_RACK && scl_fall && !arb_lost_r;
      if (mon_tick && fault_r && regs_r[ALERT_MASK_REG[3:0]][0] == 1'b0) begin
        alert_r <= 1'b1;
      end else if (served_r) begin
        alert_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      status_r <= '{overtemp: 1'b0, fan_on: 1'b0, fan_duty: 8'h00, alert_n: 1'b1};
    end else begin
      status_r.overtemp <= fault_r;
      status_r.alert_n <= ~alert_r;
      status_r.fan_on <= ge_signed(regs_r[TEMP_REM_REG[3:0]], regs_r[FAN_START_REG[3:0]]);
      if (!ge_signed(regs_r[TEMP_REM_REG[3:0]], regs_r[FAN_START_REG[3:0]])) begin
        status_r.fan_duty <= 8'h00;
      end else if (ge_signed(regs_r[TEMP_REM_REG[3:0]],
                             8'(regs_r[FAN_START_REG[3:0]] + regs_r[FAN_SPAN_REG[3:0]]))) begin
        status_r.fan_duty <= 8'hff;
      end else begin
        status_r.fan_duty <= regs_r[FAN_DUTY_REG[3:0]];
      end
    end
  end

  assign STATUS = status_r;
  assign ADDR_POINTER = ptr_r;

  AST_ACK_ON_MATCH: assert property (@(posedge CLK) disable iff (RST)
    (state_r == ST_ADDR && scl_fall && bit_cnt_r == BIT_COUNT_BYTE && !start_ev && !stop_ev
     && shift_r[7:1] == own_addr) |=> sda_oe_r && state_r == ST_AACK)
    else $error("No acknowledge on own address");
  AST_NO_ACK_OTHER: assert property (@(posedge CLK) disable iff (RST)
    (state_r == ST_ADDR && scl_fall && bit_cnt_r == BIT_COUNT_BYTE && !start_ev && !stop_ev
     && shift_r[7:1] != own_addr && shift_r[7:1] != ARA_ADDR) |=> state_r == ST_IDLE && !sda_oe_r)
    else $error("Acknowledged a foreign address");
  AST_PTR_LOAD: assert property (@(posedge CLK) disable iff (RST)
    (state_r == ST_WBYTE && scl_fall && bit_cnt_r == BIT_COUNT_BYTE && wcount_r == 2'h0
     && !start_ev && !stop_ev) |=> ptr_r == $past(shift_r))
    else $error("Pointer not loaded by first byte");
  AST_PTR_HOLD: assert property (@(posedge CLK) disable iff (RST)
    (state_r != ST_WBYTE) |=> $stable(ptr_r))
    else $error("Pointer changed outside a write");
  AST_STRAP_HOLD: assert property (@(posedge CLK) disable iff (RST)
    strap_done_r |=> $stable(strap_low_r) && strap_done_r)
    else $error("Strap bits changed after capture");
  AST_ADDR_HI: assert property (@(posedge CLK) disable iff (RST)
    (state_r == ST_AACK && !ara_r) |-> shift_r[7:3] == ADDR_HI_BITS)
    else $error("Own address malformed");
  AST_STOP_IDLE: assert property (@(posedge CLK) disable iff (RST)
    stop_ev && !start_ev |=> state_r == ST_IDLE && !sda_oe_r)
    else $error("Stop did not return to idle");
  AST_OVERTEMP: assert property (@(posedge CLK) disable iff (RST)
    fault_r |=> STATUS.overtemp)
    else $error("Overtemp output missing");
  AST_ALERT_CLEAR: assert property (@(posedge CLK) disable iff (RST)
    served_r && !(mon_tick && fault_r) |=> !alert_r)
    else $error("Alert not cleared after response");
  AST_ARB_YIELD: assert property (@(posedge CLK) disable iff (RST)
    arb_lost_r |-> !sda_oe_r)
    else $error("Kept driving after losing arbitration");
endmodule : tmsb_smbus_slave

// file: test/tmsb_host_model.sv
`timescale 1ns/1ps
module tmsb_host_model #(
  parameter int HALF = 8
) (
  input wire logic CLK,
  input wire logic sda,
  output logic scl,
  output logic sda_low,
  output logic res_valid,
  output logic res_kind,
  output logic [7:0] res_data
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    res_valid = 1'b0;
    res_kind = 1'b0;
    res_data = 8'h00;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge CLK);
  endtask : wait_clk
  // Data moves only in clock low, sampled mid-high
  task automatic bit_io(input logic b, output logic got);
    scl <= 1'b0;
    wait_clk(2);
    sda_low <= ~b;
    wait_clk(HALF);
    scl <= 1'b1;
    wait_clk(HALF);
    got = sda;
    wait_clk(HALF);
  endtask : bit_io
  // Data falls with clock high
  task automatic start();
    sda_low <= 1'b1;
    wait_clk(HALF);
  endtask : start
  // Low in clock low, released while clock high
  task automatic stop();
    scl <= 1'b0;
    wait_clk(2);
    sda_low <= 1'b1;
    wait_clk(HALF);
    scl <= 1'b1;
    wait_clk(HALF);
    sda_low <= 1'b0;
    wait_clk(HALF);
  endtask : stop
  task automatic post(input logic k, input logic [7:0] d);
    res_kind <= k;
    res_data <= d;
    res_valid <= 1'b1;
    wait_clk(1);
    res_valid <= 1'b0;
  endtask : post
  // Eight bits MSB first, ninth clock is the ack
  task automatic send(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(d[i], g);
    bit_io(1'b1, ack);
    post(1'b0, {7'h00, ack});
  endtask : send
  // One byte, zeros of p pulled as a rival would, then not-acknowledge
  task automatic recv(input logic [7:0] p, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_io(p[i], g);
      d[i] = g;
    end
    bit_io(1'b1, g);
    post(1'b1, d);
  endtask : recv
endmodule : tmsb_host_model

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import tmsb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] strap = STRAP_GND;
  tmsb_temps_t temps = '0;
  logic scl, host_low, sda, res_valid, res_kind, sda_out, sda_oe;
  logic [7:0] res_data, ptr, v, loc;
  tmsb_status_t status;
  logic [31:0] seed = 32'd11;
  logic [8:0] expq[$];
  int miscompares = 0;
  int checks_done = 0;
  logic [6:0] own;
  always #4 clk = ~clk;
  // Open drain with pull-up: low if either party pulls
  assign sda = ~((sda_oe & ~sda_out) | host_low);
  tmsb_smbus_slave dut_u (.CLK(clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .STRAP_STATE(strap), .TEMPS_IN(temps), .STATUS(status), .ADDR_POINTER(ptr));
  tmsb_host_model #(.HALF(8)) host_u (.CLK(clk), .sda(sda), .scl(scl), .sda_low(host_low),
    .res_valid(res_valid), .res_kind(res_kind), .res_data(res_data));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [1:0] low_bits(input int s);
    return (s == 0) ? LOW_BITS_GND : (s == 1) ? LOW_BITS_VCC : LOW_BITS_OPEN;
  endfunction : low_bits
  task automatic tally_and_finish();
    if (expq.size() != 0) begin
      miscompares++;
      $display("[ERR] pending results expected %0d seen %0d", 0, expq.size());
    end
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic cmp_bus(input logic [8:0] e, input logic [8:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] bus result expected %h seen %h", e, g);
    end
  endtask : cmp_bus
  task automatic cmp_port(input string what, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : cmp_port
  always @(posedge clk) begin
    logic [8:0] e;
    if (res_valid === 1'b1) begin
      e = (expq.size() > 0) ? expq.pop_front() : ~{res_kind, res_data};
      cmp_bus(e, {res_kind, res_data});
    end
  end
  // Write only: direction never changes inside a transfer
  task automatic wr(input logic [6:0] a, input logic [7:0] b0, input logic [7:0] b1,
    input int n, input logic aok);
    logic g;
    expq.push_back({8'h00, ~aok});
    host_u.start();
    host_u.send({a, 1'b0}, g);
    if (aok) begin
      expq.push_back(9'h000);
      host_u.send(b0, g);
      if (n > 1) expq.push_back(9'h000);
      if (n > 1) host_u.send(b1, g);
      if (n > 2) expq.push_back(9'h001);
      if (n > 2) host_u.send(~b1, g);
    end
    host_u.stop();
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] d, input logic aok);
    logic g;
    logic [7:0] g8;
    expq.push_back({8'h00, ~aok});
    host_u.start();
    host_u.send({a, 1'b1}, g);
    if (aok) expq.push_back({1'b1, d});
    if (aok) host_u.recv(8'hff, g8);
    host_u.stop();
  endtask : rd
  // A lower responder answers the same alert read; we must yield
  task automatic ara_lose(input logic [7:0] rival);
    logic g;
    logic [7:0] g8;
    expq.push_back(9'h000);
    host_u.start();
    host_u.send({ARA_ADDR, 1'b1}, g);
    expq.push_back({1'b1, rival});
    host_u.recv(rival, g8);
    host_u.stop();
  endtask : ara_lose
  task automatic wait_ot(input logic lvl);
    int n;
    n = 0;
    while (status.overtemp !== lvl && n < 3000) begin
      @(posedge clk);
      n++;
    end
    repeat (4) @(posedge clk);
    cmp_port("overtemp", 8'(lvl), 8'(status.overtemp));
  endtask : wait_ot
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    for (int s = 0; s < 4; s++) begin
      rst <= 1'b1;
      strap <= 2'(s);
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      // Strap moves after capture; address must not follow
      strap <= 2'((s + 1) % 3);
      own = {ADDR_HI_BITS, low_bits(s)};
      cmp_port("pointer", PTR_RESET, ptr);
      wr({ADDR_HI_BITS, low_bits((s + 1) % 3)}, 8'h03, 8'h00, 1, 1'b0);
      wr(own, 8'h03, 8'h00, 1, 1'b1);
      cmp_port("pointer", 8'h03, ptr);
    end
    cmp_port("open addr", 8'h2e, {1'b0, own});
    loc = 8'h10 + 8'(rnd() & 32'h3f);
    temps <= '{loc: loc, rem: loc};
    for (int r = 0; r < 4; r++) begin
      v = 8'(rnd());
      wr(own, 8'(r), v, 2, 1'b1);
      wr(own, FAN_SPAN_REG, 8'h00, 1, 1'b1);
      wr(own, 8'(r), 8'h00, 1, 1'b1);
      rd(own, v, 1'b1);
      rd(own, v, 1'b1);
      cmp_port("pointer", 8'(r), ptr);
    end
    wr(own, 8'h01, v, 3, 1'b1);
    rd(own, v, 1'b1);
    wr(own, 8'h20, 8'h00, 1, 1'b1);
    cmp_port("pointer", 8'h20, ptr);
    rd(own, 8'h00, 1'b1);
    wr(own, OFFSET_REG_BASE, 8'h1d, 2, 1'b1);
    repeat (int'(MON_PERIOD) + 100) @(posedge clk);
    wr(own, TEMP_LOC_REG, 8'h00, 1, 1'b1);
    rd(own, loc - 8'h03, 1'b1);
    wait_ot(1'b1);
    cmp_port("alert_n", 8'h00, 8'(status.alert_n));
    cmp_port("fan duty", 8'hff, status.fan_duty);
    wr(own, FAN_START_REG, 8'h7f, 2, 1'b1);
    wr(own, OVERTEMP_OUTPUT_LIMIT_BASE, 8'h7f, 2, 1'b1);
    wr(own, OVERTEMP_OUTPUT_LIMIT_BASE + 8'h01, 8'h7f, 2, 1'b1);
    wait_ot(1'b0);
    cmp_port("fan on", 8'h00, 8'(status.fan_on));
    cmp_port("fan duty", 8'h00, status.fan_duty);
    rd(ARA_ADDR, {own, 1'b0}, 1'b1);
    cmp_port("alert_n", 8'h01, 8'(status.alert_n));
    rd(ARA_ADDR, 8'h00, 1'b0);
    wr(own, OVERTEMP_OUTPUT_LIMIT_BASE, 8'h00, 2, 1'b1);
    wait_ot(1'b1);
    // Alert only returns on the monitor tick after the fault is seen
    repeat (int'(MON_PERIOD) + 4) @(posedge clk);
    cmp_port("alert_n", 8'h00, 8'(status.alert_n));
    // Rival 0101011 sits below our open-strap address
    ara_lose(8'h56);
    cmp_port("alert_n", 8'h00, 8'(status.alert_n));
    rd(ARA_ADDR, {own, 1'b0}, 1'b1);
    wr(own, FAN_DUTY_REG, 8'h5a, 2, 1'b1);
    wr(own, FAN_START_REG, 8'h00, 2, 1'b1);
    wr(own, FAN_SPAN_REG, 8'h7f, 2, 1'b1);
    cmp_port("fan duty", 8'h5a, status.fan_duty);
    repeat (20) @(posedge clk);
    tally_and_finish();
  end
endmodule : testbench
